// ==== src/sse_exec.sv ====
// Execution of the power-down and subtract instructions behind an Avalon-MM slave
// What this block does
// - Power-down clears watchdog counter and prescaler
// - Power-down sets the time-out flag
// - Power-down clears powerdown flag, keeps pin-wake flag
// - After power-down, sleep; no instruction executes
// - Subtract computes file minus accumulator, eight bits
// - Destination bit picks accumulator or file register
`timescale 1ns/100ps
module sse_exec #(
    parameter int PRESC_W = 8                   // Watchdog prescaler width
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,                  // Low freezes all state
    input wire logic wdog_tick_i,               // Watchdog clock tick
    input wire logic pin_change_i,              // Pin change wake event
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic osc_run_o                      // Main oscillator enable
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic {SSE_RUN, SSE_SLEEP} sse_state_t;
    sse_state_t state_q;                        // Run or sleep
    logic [7:0] acc_q;                          // Accumulator
    logic [7:0] file_q;                         // Addressed file register
    logic [7:0] watchdog_counter_q;             // Watchdog count
    logic [PRESC_W-1:0] presc_q;                // Watchdog prescaler
    logic timeout_flag_q;
    logic powerdown_flag_q;
    logic pin_change_wakeup_flag_q;
    sse_pkg::sse_alu_flags_t flags_q;           // Carry, digit carry, zero
    logic [31:0] rdata_q;                       // Registered read data
    logic ack_q;                                // One-cycle answer marker

    // ------------------------------------------------------------
    // Subtract arithmetic
    // ------------------------------------------------------------
    // Borrow-free reads as carry set, as in the usual two's complement subtract
    function automatic sse_pkg::sse_alu_res_t sse_sub(input logic [7:0] f, input logic [7:0] w);
        logic [8:0] full;
        logic [4:0] low;
        sse_pkg::sse_alu_res_t r;
        full = {1'b0, f} + {1'b0, ~w} + 9'h001;
        low = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
        r.diff = full[7:0];
        r.flags.carry = full[8];
        r.flags.digit_carry = low[4];
        r.flags.zero = (full[7:0] == 8'h00);
        return r;
    endfunction : sse_sub

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic req = (avs_read_i | avs_write_i) & clk_en_i;
    wire logic take = req & ~ack_q;             // Request accepted this cycle
    wire logic wr_take = take & avs_write_i;
    wire logic wr_cmd = wr_take & (avs_address_i == sse_pkg::ADDR_CMD) & avs_byteenable_i[0];
    wire logic wr_acc = wr_take & (avs_address_i == sse_pkg::ADDR_ACC) & avs_byteenable_i[0];
    wire logic wr_file = wr_take & (avs_address_i == sse_pkg::ADDR_FILE) & avs_byteenable_i[0];
    wire logic [1:0] cmd_op = avs_writedata_i[sse_pkg::CMD_OP_LSB +: 2];
    wire logic cmd_dest = avs_writedata_i[sse_pkg::CMD_DEST_BIT];
    wire logic cmd_wake = avs_writedata_i[sse_pkg::CMD_WAKE_BIT];
    wire logic asleep = (state_q == SSE_SLEEP);
    // Instructions are ignored while asleep; only wake leaves sleep
    wire logic do_sub = wr_cmd & ~asleep & (cmd_op == sse_pkg::OP_SUB);
    wire logic do_sleep = wr_cmd & ~asleep & (cmd_op == sse_pkg::OP_SLEEP);
    wire logic do_wake = asleep & ((wr_cmd & cmd_wake) | pin_change_i);
    wire sse_pkg::sse_alu_res_t sub_res = sse_sub(file_q, acc_q);
    wire logic presc_wrap = wdog_tick_i & (&presc_q);

    // Read mux; unmapped offsets read zero
    logic [31:0] rmux;
    always_comb begin
        unique case (avs_address_i)
            sse_pkg::ADDR_ACC: rmux = {24'h000000, acc_q};
            sse_pkg::ADDR_FILE: rmux = {24'h000000, file_q};
            sse_pkg::ADDR_STAT: begin
                rmux = 32'h00000000;
                rmux[sse_pkg::ST_CARRY] = flags_q.carry;
                rmux[sse_pkg::ST_DIGIT] = flags_q.digit_carry;
                rmux[sse_pkg::ST_ZERO] = flags_q.zero;
                rmux[sse_pkg::ST_TIMEOUT] = timeout_flag_q;
                rmux[sse_pkg::ST_POWERDOWN] = powerdown_flag_q;
                rmux[sse_pkg::ST_PINWAKE] = pin_change_wakeup_flag_q;
                rmux[sse_pkg::ST_ASLEEP] = asleep;
                rmux[sse_pkg::ST_WDOG_LSB +: 8] = watchdog_counter_q;
            end
            default: rmux = 32'h00000000;
        endcase
    end

    // One wait state: answer lands on the cycle after the request is seen
    // Held back while frozen: a marker left standing must not answer a later request
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(ack_q & clk_en_i);
    assign avs_readdata_o = rdata_q;
    assign osc_run_o = ~asleep;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else if (clk_en_i) begin
            ack_q <= take;
            if (take & avs_read_i) begin
                rdata_q <= rmux;
            end
        end
    end

    // ------------------------------------------------------------
    // Run/sleep state
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= SSE_RUN;
        end else if (clk_en_i) begin
            if (do_sleep) begin
                state_q <= SSE_SLEEP;
            end else if (do_wake) begin
                state_q <= SSE_RUN;
            end
        end
    end

    // ------------------------------------------------------------
    // Watchdog counter and prescaler; power-down clear wins over a tick
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            watchdog_counter_q <= sse_pkg::WDOG_CLEAR;
            presc_q <= '0;
        end else if (clk_en_i) begin
            if (do_sleep) begin
                watchdog_counter_q <= sse_pkg::WDOG_CLEAR;
                presc_q <= '0;
            end else if (wdog_tick_i) begin
                presc_q <= presc_q + 1'b1;
                if (presc_wrap) begin
                    watchdog_counter_q <= watchdog_counter_q + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Reset-cause flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            timeout_flag_q <= 1'b1;
            powerdown_flag_q <= 1'b1;
            pin_change_wakeup_flag_q <= 1'b0;
        end else if (clk_en_i) begin
            if (do_sleep) begin
                timeout_flag_q <= 1'b1;
                powerdown_flag_q <= 1'b0;
            end
            // Pin-change flag is untouched by power-down; set by a wake from pin
            if (asleep & pin_change_i & ~do_sleep) begin
                pin_change_wakeup_flag_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Accumulator, file register and arithmetic flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_q <= sse_pkg::ACC_RST;
            file_q <= sse_pkg::FILE_RST;
            flags_q <= '0;
        end else if (clk_en_i) begin
            if (do_sub) begin
                flags_q <= sub_res.flags;
                if (cmd_dest) begin
                    file_q <= sub_res.diff;
                end else begin
                    acc_q <= sub_res.diff;
                end
            end else begin
                if (wr_acc) begin
                    acc_q <= avs_writedata_i[7:0];
                end
                if (wr_file) begin
                    file_q <= avs_writedata_i[7:0];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_sleep_cmd;
        clk_en_i && do_sleep;
    endsequence

    property p_wdog_clear;
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_sleep_cmd |=> (watchdog_counter_q == 8'h00) && (presc_q == '0);
    endproperty
    a_wdog_clear: assert property (p_wdog_clear) else $error("watchdog not cleared");

    property p_timeout_set;
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_sleep_cmd |=> timeout_flag_q;
    endproperty
    a_timeout_set: assert property (p_timeout_set) else $error("time-out flag not set");

    property p_pd_clear;
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_sleep_cmd |=> !powerdown_flag_q &&
            (pin_change_wakeup_flag_q == $past(pin_change_wakeup_flag_q));
    endproperty
    a_pd_clear: assert property (p_pd_clear) else $error("power-down flags wrong");

    property p_sleep_osc;
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_sleep_cmd |=> !osc_run_o;
    endproperty
    a_sleep_osc: assert property (p_sleep_osc) else $error("oscillator still runs");

    // A command taken while asleep leaves operands and flags alone
    property p_no_exec_asleep;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (asleep && wr_cmd) |=> $stable(acc_q) && $stable(file_q) && $stable(flags_q) &&
            $stable(powerdown_flag_q);
    endproperty
    a_no_exec_asleep: assert property (p_no_exec_asleep) else $error("executed asleep");

    property p_sub_acc;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (clk_en_i && do_sub && !cmd_dest) |=>
            acc_q == 8'($past(file_q) - $past(acc_q)) && file_q == $past(file_q);
    endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("subtract to acc wrong");

    property p_sub_file;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (clk_en_i && do_sub && cmd_dest) |=>
            file_q == 8'($past(file_q) - $past(acc_q)) && acc_q == $past(acc_q);
    endproperty
    a_sub_file: assert property (p_sub_file) else $error("subtract to file wrong");

    property p_sub_flags;
        @(posedge core_clk_i) disable iff (!rstn_i)
        (clk_en_i && do_sub) |=> flags_q.carry == ($past(file_q) >= $past(acc_q)) &&
            flags_q.digit_carry == ($past(file_q[3:0]) >= $past(acc_q[3:0])) &&
            flags_q.zero == ($past(file_q) == $past(acc_q));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

endmodule : sse_exec

// ==== src/sse_pkg.sv ====
// Package for the power-down and subtract execution block
package sse_pkg;

    // ------------------------------------------------------------
    // Register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CMD = 4'h0;     // Write: opcode, destination and wake bits
    localparam logic [3:0] ADDR_ACC = 4'h4;     // Accumulator
    localparam logic [3:0] ADDR_FILE = 4'h8;    // File register operand/result
    localparam logic [3:0] ADDR_STAT = 4'hc;    // Status flags and watchdog counter

    // ------------------------------------------------------------
    // Command field positions and codes
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;              // Opcode in bits 1:0
    localparam int CMD_DEST_BIT = 4;            // Destination bit
    localparam int CMD_WAKE_BIT = 8;            // Wake-up request
    localparam logic [1:0] OP_NONE = 2'h0;
    localparam logic [1:0] OP_SLEEP = 2'h1;
    localparam logic [1:0] OP_SUB = 2'h2;

    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_POWERDOWN = 4;
    localparam int ST_PINWAKE = 5;
    localparam int ST_ASLEEP = 6;
    localparam int ST_WDOG_LSB = 8;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] WDOG_CLEAR = 8'h00;  // Watchdog value after power-down
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;

    // Arithmetic flags carried together
    typedef struct packed {
        logic carry;
        logic digit_carry;
        logic zero;
    } sse_alu_flags_t;

    typedef struct packed {
        logic [7:0] diff;
        sse_alu_flags_t flags;
    } sse_alu_res_t;

endpackage : sse_pkg

// ==== verif/sse_exec_bench.sv ====
// Self-checking bench for the power-down and subtract execution block
`timescale 1ns/100ps
module sse_exec_bench;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic wdog_tick_i = 1'b0;
    logic pin_change_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic osc_run_o;
    int mismatches = 0; // Failed comparisons
    int num_checks = 0; // All comparisons
    logic [31:0] rd; // Last read word

    // Clock enable driven by the bench so a freeze can be exercised
    sse_exec DUT (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i),
        .wdog_tick_i(wdog_tick_i), .pin_change_i(pin_change_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .osc_run_o(osc_run_o));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // 100 MHz core clock
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One bus cycle; waitrequest and read data are taken at the same rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] q);
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        // Wait for the answer; a stuck slave is caught by the bench watchdog
        do begin
            @(posedge core_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hf, rd);
    endtask : wr

    // Read and compare under a mask
    task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hf, rd);
        chk(what, exp, rd & m);
    endtask : rdc

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Status after reset, unmapped read, write without lane 0
    task automatic test_reset;
        rdc("status", sse_pkg::ADDR_STAT, 32'hffff, 32'h0018);
        rdc("unmapped", 4'h2, 32'hffffffff, 32'h0);
        wr(sse_pkg::ADDR_ACC, 32'h33);
        bus(1'b1, sse_pkg::ADDR_ACC, 32'h55, 4'he, rd);
        rdc("acc lane", sse_pkg::ADDR_ACC, 32'hff, 32'h33);
        $display("test_reset ended");
    endtask : test_reset

    // Subtract file minus accumulator; expectations from plain arithmetic
    task automatic sub_case(input logic [7:0] f, input logic [7:0] a, input logic d);
        logic [7:0] diff;
        logic [2:0] fl;
        diff = f - a;
        fl = {diff == 8'h00, f[3:0] >= a[3:0], f >= a};
        wr(sse_pkg::ADDR_ACC, {24'h0, a});
        wr(sse_pkg::ADDR_FILE, {24'h0, f});
        wr(sse_pkg::ADDR_CMD, {27'h0, d, 2'h0, sse_pkg::OP_SUB});
        rdc("acc", sse_pkg::ADDR_ACC, 32'hff, {24'h0, d ? a : diff});
        rdc("file", sse_pkg::ADDR_FILE, 32'hff, {24'h0, d ? diff : f});
        rdc("flags", sse_pkg::ADDR_STAT, 32'h7, {29'h0, fl});
    endtask : sub_case

    // Positive, zero, negative, nibble borrow, both destinations
    task automatic test_sub;
        sub_case(8'h03, 8'h02, 1'b1);
        sub_case(8'h02, 8'h02, 1'b1);
        sub_case(8'h01, 8'h02, 1'b1);
        sub_case(8'h10, 8'h01, 1'b0);
        sub_case(8'h9f, 8'h0f, 1'b0);
        $display("test_sub ended");
    endtask : test_sub

    // Enable dropped mid-handshake: the answer waits and the write lands once
    task automatic test_freeze;
        @(posedge core_clk_i);
        avs_address_i <= sse_pkg::ADDR_ACC;
        avs_write_i <= 1'b1;
        avs_writedata_i <= 32'h5a;
        avs_byteenable_i <= 4'hf;
        @(posedge core_clk_i);
        clk_en_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        chk("frozen wait", 32'h1, {31'h0, avs_waitrequest_o});
        clk_en_i <= 1'b1;
        do begin
            @(posedge core_clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
        rdc("acc thawed", sse_pkg::ADDR_ACC, 32'hff, 32'h5a);
        $display("test_freeze ended");
    endtask : test_freeze

    // Power-down with a running watchdog, refused command, both wake paths
    task automatic test_sleep;
        logic [31:0] fv;
        logic [31:0] av;
        // 520 ticks step the counter twice through the 8-bit prescaler
        repeat (520) begin
            @(posedge core_clk_i);
            wdog_tick_i <= 1'b1;
            @(posedge core_clk_i);
            wdog_tick_i <= 1'b0;
        end
        rdc("wdog", sse_pkg::ADDR_STAT, 32'hff00, 32'h0200);
        wr(sse_pkg::ADDR_CMD, {30'h0, sse_pkg::OP_SLEEP});
        @(negedge core_clk_i);
        chk("osc asleep", 32'h0, {31'h0, osc_run_o});
        rdc("sleep status", sse_pkg::ADDR_STAT, 32'hff78, 32'h0048);
        bus(1'b0, sse_pkg::ADDR_FILE, 32'h0, 4'hf, fv);
        bus(1'b0, sse_pkg::ADDR_ACC, 32'h0, 4'hf, av);
        // Subtract to the file register; accumulator is nonzero so it would show
        wr(sse_pkg::ADDR_CMD, {27'h0, 1'b1, 2'h0, sse_pkg::OP_SUB});
        rdc("file asleep", sse_pkg::ADDR_FILE, 32'hff, fv & 32'hff);
        rdc("acc asleep", sse_pkg::ADDR_ACC, 32'hff, av & 32'hff);
        // Pin change wakes and marks the cause
        @(posedge core_clk_i);
        pin_change_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        pin_change_i <= 1'b0;
        @(negedge core_clk_i);
        chk("osc woken", 32'h1, {31'h0, osc_run_o});
        rdc("pin wake", sse_pkg::ADDR_STAT, 32'h0060, 32'h0020);
        // Second power-down must keep the pin-change flag
        wr(sse_pkg::ADDR_CMD, {30'h0, sse_pkg::OP_SLEEP});
        rdc("keep pinwake", sse_pkg::ADDR_STAT, 32'hff78, 32'h0068);
        wr(sse_pkg::ADDR_CMD, 32'h100);
        @(negedge core_clk_i);
        chk("osc cmd wake", 32'h1, {31'h0, osc_run_o});
        $display("test_sleep ended");
    endtask : test_sleep

    // ----------------------------------------
    // Verdict and sequencing
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // Main sequence after 12 cycles of reset
    initial begin
        repeat (12) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        test_reset;
        test_sub;
        test_freeze;
        test_sleep;
        end_of_test;
    end

    // Tests need about 1200 cycles; 5000 means a hang
    initial begin
        repeat (5000) @(posedge core_clk_i);
        mismatches++;
        end_of_test;
    end
endmodule : sse_exec_bench
